// ==== hdl/upm_pkg.sv ====
// Constants and types shared by the user-port pass-through stage
//
// Notes on behaviour
// - Request taken when request and ready high
// - Device raises user write-data request when controller asks in user mode
// - User mode forwards refresh request to controller
// - User mode forwards burst-begin to controller
// - Read data passes in user mode, else low
// - Read valid passes in user mode, else low
// - Init done passes in user mode, else low
// - Refresh ack passes in user mode, else low
// - Calibration-complete rises only after calibration finished
package upm_pkg;

   localparam int UPM_DATA_W  = 32;
   localparam int UPM_ADDR_W  = 24;
   localparam int UPM_BE_W    = UPM_DATA_W / 8;
   localparam int UPM_SIZE_W  = 1;

   localparam logic [UPM_SIZE_W-1:0] UPM_SIZE_ONE = 1'h1;

   typedef enum logic [1:0] {
      UPM_WAIT_INIT = 2'b00,
      UPM_CALIB     = 2'b01,
      UPM_USER      = 2'b10
   } upm_state_t;

   localparam upm_state_t UPM_STATE_RST = UPM_WAIT_INIT;
   localparam logic       UPM_MODE_RST  = 1'h0;
   localparam logic [UPM_DATA_W-1:0] UPM_RDATA_RST = 32'h0000_0000;

   typedef struct packed {
      upm_state_t state;
      logic       usr_mode;
   } upm_ctrl_t;

   typedef struct packed {
      logic [UPM_DATA_W-1:0] rdata;
      logic                  rdata_valid;
      logic                  init_done;
      logic                  refresh_ack;
   } upm_resp_t;

endpackage : upm_pkg

// ==== hdl/upm_resp_gate.sv ====
// Registered gate for controller responses toward one requester
module upm_resp_gate (
   input  wire logic                           sys_clk,
   input  wire logic                           rstn,
   input  wire logic                           clk_en,
   input  wire logic                           gate_open,
   input  wire logic [upm_pkg::UPM_DATA_W-1:0] ctl_rdata,
   input  wire logic                           ctl_rdata_valid,
   input  wire logic                           ctl_init_done,
   input  wire logic                           ctl_refresh_ack,
   output logic      [upm_pkg::UPM_DATA_W-1:0] out_rdata,
   output logic                                out_rdata_valid,
   output logic                                out_init_done,
   output logic                                out_refresh_ack
);

   upm_pkg::upm_resp_t resp;
   upm_pkg::upm_resp_t next_resp;

   // A closed gate forces every bit low on the next clock with clk_en high; while clk_en is low all bits hold
   always_comb begin
      next_resp = resp;
      if (clk_en) begin
         next_resp.rdata       = gate_open ? ctl_rdata : upm_pkg::UPM_RDATA_RST;
         next_resp.rdata_valid = gate_open & ctl_rdata_valid;
         next_resp.init_done   = gate_open & ctl_init_done;
         next_resp.refresh_ack = gate_open & ctl_refresh_ack;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         resp <= '0;
      end else begin
         resp <= next_resp;
      end
   end

   assign out_rdata       = resp.rdata;
   assign out_rdata_valid = resp.rdata_valid;
   assign out_init_done   = resp.init_done;
   assign out_refresh_ack = resp.refresh_ack;

   rdata_pass_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en |=> out_rdata == (($past(gate_open)) ? $past(ctl_rdata) : '0))
      else $error("Read data does not match gated controller data");

   valid_pass_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en |=> out_rdata_valid == ($past(gate_open) && $past(ctl_rdata_valid)))
      else $error("Read valid does not follow gated controller valid");

   init_pass_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && !gate_open |=> !out_init_done)
      else $error("Init done seen while gate closed");

   ack_pass_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && gate_open && ctl_refresh_ack |=> out_refresh_ack)
      else $error("Refresh acknowledge lost while gate open");

endmodule : upm_resp_gate

// ==== hdl/upm_passthrough.sv ====
// User-port pass-through between user logic, calibration sequencer and controller
module upm_passthrough (
   input  wire logic                           sys_clk,
   input  wire logic                           rstn,
   input  wire logic                           clk_en,
   // User side
   input  wire logic [upm_pkg::UPM_ADDR_W-1:0] user_address,
   input  wire logic [upm_pkg::UPM_BE_W-1:0]   user_byte_enables,
   input  wire logic                           user_read_req,
   input  wire logic                           user_write_req,
   input  wire logic [upm_pkg::UPM_SIZE_W-1:0] user_size,
   input  wire logic [upm_pkg::UPM_DATA_W-1:0] user_wdata,
   input  wire logic                           user_refresh_req,
   input  wire logic                           user_burstbegin,
   output logic                                user_ready,
   output logic                                user_wdata_req,
   output logic      [upm_pkg::UPM_DATA_W-1:0] user_rdata,
   output logic                                user_rdata_valid,
   output logic                                user_init_done,
   output logic                                user_refresh_ack,
   // Calibration sequencer side
   input  wire logic [upm_pkg::UPM_ADDR_W-1:0] seq_address,
   input  wire logic [upm_pkg::UPM_BE_W-1:0]   seq_byte_enables,
   input  wire logic                           seq_read_req,
   input  wire logic                           seq_write_req,
   input  wire logic [upm_pkg::UPM_DATA_W-1:0] seq_wdata,
   input  wire logic                           seq_refresh_req,
   input  wire logic                           seq_burstbegin,
   input  wire logic                           seq_cal_done,
   output logic                                seq_ready,
   output logic                                seq_wdata_req,
   output logic      [upm_pkg::UPM_DATA_W-1:0] seq_rdata,
   output logic                                seq_rdata_valid,
   output logic                                seq_init_done,
   output logic                                seq_refresh_ack,
   // Controller side
   output logic      [upm_pkg::UPM_ADDR_W-1:0] ctl_address,
   output logic      [upm_pkg::UPM_BE_W-1:0]   ctl_byte_enables,
   output logic                                ctl_read_req,
   output logic                                ctl_write_req,
   output logic      [upm_pkg::UPM_SIZE_W-1:0] ctl_size,
   output logic      [upm_pkg::UPM_DATA_W-1:0] ctl_wdata,
   output logic                                ctl_refresh_req,
   output logic                                ctl_burstbegin,
   output logic                                ctl_usr_mode_rdy,
   input  wire logic                           ctl_ready,
   input  wire logic                           ctl_wdata_req,
   input  wire logic [upm_pkg::UPM_DATA_W-1:0] ctl_rdata,
   input  wire logic                           ctl_rdata_valid,
   input  wire logic                           ctl_init_done,
   input  wire logic                           ctl_refresh_ack
);

   upm_pkg::upm_ctrl_t ctrl;
   upm_pkg::upm_ctrl_t next_ctrl;

   // Mode sequencing: wait for the controller, calibrate, then hand over.
   // A drop of the sequencer's done returns to calibration, so a
   // recalibration takes the port away from user logic cleanly.
   always_comb begin
      next_ctrl = ctrl;
      if (clk_en) begin
         case (ctrl.state)
            upm_pkg::UPM_WAIT_INIT: begin
               if (ctl_init_done) begin
                  next_ctrl.state = upm_pkg::UPM_CALIB;
               end
            end
            upm_pkg::UPM_CALIB: begin
               if (!ctl_init_done) begin
                  next_ctrl.state = upm_pkg::UPM_WAIT_INIT;
               end else if (seq_cal_done) begin
                  next_ctrl.state = upm_pkg::UPM_USER;
               end
            end
            upm_pkg::UPM_USER: begin
               if (!ctl_init_done) begin
                  next_ctrl.state = upm_pkg::UPM_WAIT_INIT;
               end else if (!seq_cal_done) begin
                  next_ctrl.state = upm_pkg::UPM_CALIB;
               end
            end
            default: begin
               next_ctrl.state = upm_pkg::UPM_STATE_RST;
            end
         endcase
         next_ctrl.usr_mode = (next_ctrl.state == upm_pkg::UPM_USER);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl.state    <= upm_pkg::UPM_STATE_RST;
         ctrl.usr_mode <= upm_pkg::UPM_MODE_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   assign ctl_usr_mode_rdy = ctrl.usr_mode;

   // Request path stays combinational so the ready handshake is not skewed
   // against the request by a register stage.
   always_comb begin
      if (ctrl.usr_mode) begin
         ctl_address      = user_address;
         ctl_byte_enables = user_byte_enables;
         ctl_read_req     = user_read_req;
         ctl_write_req    = user_write_req;
         ctl_size         = user_size;
         ctl_wdata        = user_wdata;
         ctl_refresh_req  = user_refresh_req;
         ctl_burstbegin   = user_burstbegin;
      end else begin
         ctl_address      = seq_address;
         ctl_byte_enables = seq_byte_enables;
         ctl_read_req     = seq_read_req;
         ctl_write_req    = seq_write_req;
         ctl_size         = upm_pkg::UPM_SIZE_ONE;
         ctl_wdata        = seq_wdata;
         ctl_refresh_req  = seq_refresh_req;
         ctl_burstbegin   = seq_burstbegin;
      end
   end

   assign user_ready     = ctrl.usr_mode & ctl_ready;
   assign seq_ready      = ~ctrl.usr_mode & ctl_ready;
   assign user_wdata_req = ctrl.usr_mode & ctl_wdata_req;
   assign seq_wdata_req  = ~ctrl.usr_mode & ctl_wdata_req;

   upm_resp_gate u_user_gate (
      .sys_clk         (sys_clk),
      .rstn            (rstn),
      .clk_en          (clk_en),
      .gate_open       (ctrl.usr_mode),
      .ctl_rdata       (ctl_rdata),
      .ctl_rdata_valid (ctl_rdata_valid),
      .ctl_init_done   (ctl_init_done),
      .ctl_refresh_ack (ctl_refresh_ack),
      .out_rdata       (user_rdata),
      .out_rdata_valid (user_rdata_valid),
      .out_init_done   (user_init_done),
      .out_refresh_ack (user_refresh_ack)
   );

   upm_resp_gate u_seq_gate (
      .sys_clk         (sys_clk),
      .rstn            (rstn),
      .clk_en          (clk_en),
      .gate_open       (~ctrl.usr_mode),
      .ctl_rdata       (ctl_rdata),
      .ctl_rdata_valid (ctl_rdata_valid),
      .ctl_init_done   (ctl_init_done),
      .ctl_refresh_ack (ctl_refresh_ack),
      .out_rdata       (seq_rdata),
      .out_rdata_valid (seq_rdata_valid),
      .out_init_done   (seq_init_done),
      .out_refresh_ack (seq_refresh_ack)
   );

   user_accept_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         user_ready |-> ctl_ready && ctl_usr_mode_rdy && (ctl_read_req == user_read_req)
                        && (ctl_write_req == user_write_req) && (ctl_address == user_address))
      else $error("User ready without a matching controller handshake");

   wdata_req_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         user_wdata_req == (ctl_wdata_req && ctl_usr_mode_rdy))
      else $error("Write-data request not passed in user mode");

   refresh_fwd_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         ctl_usr_mode_rdy |-> ctl_refresh_req == user_refresh_req)
      else $error("Refresh request not forwarded in user mode");

   burst_fwd_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         ctl_usr_mode_rdy |-> ctl_burstbegin == user_burstbegin)
      else $error("Burst begin not forwarded in user mode");

   cal_gate_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         $rose(ctl_usr_mode_rdy) |-> $past(seq_cal_done) && $past(ctl_init_done))
      else $error("User mode entered before calibration finished");

   no_leak_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         !ctl_usr_mode_rdy |-> ctl_refresh_req == seq_refresh_req
                               && ctl_burstbegin == seq_burstbegin && !user_ready)
      else $error("User strobe leaked to controller outside user mode");

   init_follow_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && ctl_usr_mode_rdy && $past(ctl_usr_mode_rdy) && ctl_init_done
         |=> user_init_done)
      else $error("Init done not passed to user in user mode");

   rdata_low_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && !ctl_usr_mode_rdy |=> user_rdata == '0 && !user_refresh_ack)
      else $error("User responses not held low outside user mode");

   valid_low_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && !ctl_usr_mode_rdy |=> !user_rdata_valid && !user_init_done)
      else $error("User valid or init done not held low outside user mode");

   ack_follow_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && ctl_usr_mode_rdy && ctl_refresh_ack |=> user_refresh_ack)
      else $error("Refresh acknowledge not passed to user in user mode");

   mode_exit_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         clk_en && ctl_usr_mode_rdy && !seq_cal_done |=> !ctl_usr_mode_rdy)
      else $error("User mode kept after calibration was withdrawn");

   // A frozen block must not hand the port over behind the sequencer's back
   mode_hold_a:
      assert property (@(posedge sys_clk) disable iff (!rstn)
         !clk_en |=> $stable(ctl_usr_mode_rdy))
      else $error("Mode changed while clock enable was low");

endmodule : upm_passthrough

// ==== tb/upm_user_model.sv ====
// Behavioural user-side requester: one read or write per start pulse
module upm_user_model (
   input  wire logic                           sys_clk,
   input  wire logic                           start,
   input  wire logic                           is_wr,
   input  wire logic [upm_pkg::UPM_ADDR_W-1:0] addr,
   input  wire logic                           user_ready,
   output logic      [upm_pkg::UPM_ADDR_W-1:0] user_address,
   output logic      [upm_pkg::UPM_BE_W-1:0]   user_byte_enables,
   output logic                                user_read_req,
   output logic                                user_write_req,
   output logic      [upm_pkg::UPM_SIZE_W-1:0] user_size,
   output logic      [upm_pkg::UPM_DATA_W-1:0] user_wdata,
   output logic                                busy
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      busy = 1'b0;
      user_read_req = 1'b0;
      user_write_req = 1'b0;
      user_address = 24'h000000;
      user_byte_enables = 4'h0;
      user_wdata = 32'h00000000;
      user_size = 1'h1;
   end
   always @(posedge sys_clk) begin
      if (!busy && start) begin
         busy <= 1'b1;
         user_address <= addr;
         user_byte_enables <= addr[3:0];
         user_wdata <= {8'h5a, addr};
         user_read_req <= !is_wr;
         user_write_req <= is_wr;
      end else if (busy && user_ready) begin
         // Requests drop and released address, enables and data show the inverse so stale values never look valid
         busy <= 1'b0;
         user_read_req <= 1'b0;
         user_write_req <= 1'b0;
         user_address <= ~user_address;
         user_byte_enables <= ~user_byte_enables;
         user_wdata <= ~user_wdata;
      end
   end
endmodule : upm_user_model

// ==== tb/upm_passthrough_tb.sv ====
// Self-checking bench for the user-port pass-through stage
module upm_passthrough_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rstn, start, is_wr, busy, seq_strb, seq_cal_done, user_refresh_req, user_burstbegin;
   logic clk_en, seq_ready, seq_wdata_req, seq_rdata_valid, seq_init_done, seq_refresh_ack;
   logic ctl_ready, ctl_wdata_req, ctl_rdata_valid, ctl_init_done, ctl_refresh_ack;
   logic user_read_req, user_write_req, user_ready, user_wdata_req, user_rdata_valid, user_init_done;
   logic user_refresh_ack, ctl_read_req, ctl_write_req, ctl_refresh_req, ctl_burstbegin, ctl_usr_mode_rdy;
   logic [upm_pkg::UPM_ADDR_W-1:0] addr, seq_addr, user_address, ctl_address;
   logic [upm_pkg::UPM_BE_W-1:0]   user_byte_enables, ctl_byte_enables;
   logic [upm_pkg::UPM_SIZE_W-1:0] user_size, ctl_size;
   logic [upm_pkg::UPM_DATA_W-1:0] user_wdata, ctl_wdata, user_rdata, ctl_rdata, seq_rdata;
   int                             n_fail, num_checks;

   upm_user_model upm_user_model_inst (.sys_clk(sys_clk), .start(start), .is_wr(is_wr), .addr(addr),
      .user_ready(user_ready), .user_address(user_address), .user_byte_enables(user_byte_enables),
      .user_read_req(user_read_req), .user_write_req(user_write_req), .user_size(user_size),
      .user_wdata(user_wdata), .busy(busy));

   upm_passthrough upm_passthrough_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
      .user_address(user_address), .user_byte_enables(user_byte_enables), .user_read_req(user_read_req),
      .user_write_req(user_write_req), .user_size(user_size), .user_wdata(user_wdata),
      .user_refresh_req(user_refresh_req), .user_burstbegin(user_burstbegin), .user_ready(user_ready),
      .user_wdata_req(user_wdata_req), .user_rdata(user_rdata), .user_rdata_valid(user_rdata_valid),
      .user_init_done(user_init_done), .user_refresh_ack(user_refresh_ack), .seq_address(seq_addr),
      .seq_byte_enables(4'h0), .seq_read_req(seq_strb), .seq_write_req(1'b0), .seq_wdata(32'h0),
      .seq_refresh_req(seq_strb), .seq_burstbegin(seq_strb), .seq_cal_done(seq_cal_done), .seq_ready(seq_ready),
      .seq_wdata_req(seq_wdata_req), .seq_rdata(seq_rdata), .seq_rdata_valid(seq_rdata_valid),
      .seq_init_done(seq_init_done), .seq_refresh_ack(seq_refresh_ack),
      .ctl_address(ctl_address), .ctl_byte_enables(ctl_byte_enables), .ctl_read_req(ctl_read_req),
      .ctl_write_req(ctl_write_req), .ctl_size(ctl_size), .ctl_wdata(ctl_wdata),
      .ctl_refresh_req(ctl_refresh_req), .ctl_burstbegin(ctl_burstbegin), .ctl_usr_mode_rdy(ctl_usr_mode_rdy),
      .ctl_ready(ctl_ready), .ctl_wdata_req(ctl_wdata_req), .ctl_rdata(ctl_rdata),
      .ctl_rdata_valid(ctl_rdata_valid), .ctl_init_done(ctl_init_done), .ctl_refresh_ack(ctl_refresh_ack));

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk

   task complete_run;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   task edge_n(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : edge_n

   task t_calib;
      @(posedge sys_clk);
      ctl_init_done <= 1'b1;
      user_refresh_req <= 1'b1;
      user_burstbegin <= 1'b1;
      ctl_rdata <= 32'hc3a5_0f1e;
      ctl_rdata_valid <= 1'b1;
      ctl_refresh_ack <= 1'b1;
      edge_n(2);
      chk(ctl_usr_mode_rdy, 0, "mode before calibration end");
      chk(user_ready, 0, "ready outside user mode");
      chk(ctl_refresh_req, 0, "user refresh leaked");
      chk(ctl_burstbegin, 0, "user burst begin leaked");
      chk(user_rdata, 0, "read data not low");
      chk(user_rdata_valid, 0, "read valid not low");
      chk(user_init_done, 0, "init done not low");
      chk(user_refresh_ack, 0, "refresh ack not low");
      chk(seq_ready, 1, "calibration ready lost");
      chk(seq_rdata, 32'hc3a5_0f1e, "calibration read data lost");
      chk(seq_rdata_valid, 1, "calibration read valid lost");
      chk(seq_init_done, 1, "calibration init done lost");
      chk(seq_refresh_ack, 1, "calibration refresh ack lost");
      @(posedge sys_clk);
      seq_strb <= 1'b1;
      ctl_refresh_ack <= 1'b0;
      edge_n(0);
      chk(ctl_refresh_req, 1, "calibration refresh lost");
      chk(ctl_address, seq_addr, "calibration address lost");
      @(posedge sys_clk);
      seq_strb <= 1'b0;
      $display("test calib done");
   endtask : t_calib

   task t_enter;
      @(posedge sys_clk);
      seq_cal_done <= 1'b1;
      ctl_wdata_req <= 1'b1;
      edge_n(0);
      chk(ctl_usr_mode_rdy, 0, "mode too early");
      chk(user_wdata_req, 0, "write data request too early");
      chk(seq_wdata_req, 1, "calibration write data request");
      @(posedge sys_clk);
      ctl_refresh_ack <= 1'b1;
      edge_n(0);
      chk(ctl_usr_mode_rdy, 1, "mode not entered");
      chk(user_ready, 1, "ready not passed");
      chk(seq_ready, 0, "calibration ready in user mode");
      chk(ctl_refresh_req, 1, "refresh not forwarded");
      chk(ctl_burstbegin, 1, "burst begin not forwarded");
      chk(user_wdata_req, 1, "write data request");
      @(posedge sys_clk);
      ctl_refresh_ack <= 1'b0;
      edge_n(0);
      chk(user_rdata, 32'hc3a5_0f1e, "read data");
      chk(user_rdata_valid, 1, "read valid");
      chk(user_init_done, 1, "init done");
      chk(user_refresh_ack, 1, "refresh ack");
      chk(seq_rdata_valid, 0, "calibration valid in user mode");
      edge_n(1);
      chk(user_refresh_ack, 0, "refresh ack not a pulse");
      $display("test enter done");
   endtask : t_enter

   task t_req(input logic wr);
      @(posedge sys_clk);
      ctl_ready <= 1'b0;
      start <= 1'b1;
      is_wr <= wr;
      addr <= 24'h3c5a90 + wr;
      @(posedge sys_clk);
      start <= 1'b0;
      edge_n(2);
      chk(ctl_read_req, !wr, "read request");
      chk(ctl_write_req, wr, "write request");
      chk(ctl_address, addr, "request address");
      chk(ctl_size, 1, "burst size");
      if (wr) chk(ctl_byte_enables, addr[3:0], "byte enables");
      if (wr) chk(ctl_wdata, {8'h5a, addr}, "write data");
      chk(user_ready, 0, "ready while stalled");
      @(posedge sys_clk);
      ctl_ready <= 1'b1;
      edge_n(0);
      chk(user_ready, 1, "ready not shown");
      edge_n(1);
      chk(busy, 0, "request not taken");
      chk(ctl_read_req | ctl_write_req, 0, "request after accept");
      $display("test request done");
   endtask : t_req

   task t_leave;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      seq_cal_done <= 1'b0;
      edge_n(1);
      chk(ctl_usr_mode_rdy, 1, "mode moved while frozen");
      @(posedge sys_clk);
      clk_en <= 1'b1;
      edge_n(1);
      chk(ctl_usr_mode_rdy, 0, "mode not left");
      chk(ctl_refresh_req, 0, "refresh leaked after exit");
      chk(user_ready, 0, "ready after exit");
      chk(user_wdata_req, 0, "write data request after exit");
      edge_n(1);
      chk(user_rdata_valid, 0, "valid after exit");
      chk(user_rdata, 0, "data after exit");
      @(posedge sys_clk);
      ctl_init_done <= 1'b0;
      seq_cal_done <= 1'b1;
      edge_n(1);
      chk(ctl_usr_mode_rdy, 0, "mode entered without init done");
      chk(seq_init_done, 0, "calibration init done stuck");
      $display("test leave done");
   endtask : t_leave

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (2000) @(posedge sys_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      {rstn, start, is_wr, seq_strb, seq_cal_done, user_refresh_req, user_burstbegin} = 7'h0;
      {ctl_wdata_req, ctl_rdata_valid, ctl_init_done, ctl_refresh_ack} = 4'h0;
      ctl_ready = 1'b1;
      clk_en = 1'b1;
      addr = 24'h000000;
      seq_addr = 24'h5a0f33;
      ctl_rdata = 32'h00000000;
      n_fail = 0;
      num_checks = 0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      edge_n(1);
      chk(user_ready, 0, "ready after reset");
      chk(ctl_usr_mode_rdy, 0, "mode after reset");
      t_calib();
      t_enter();
      t_req(1'b0);
      t_req(1'b1);
      t_leave();
      complete_run();
   end
endmodule : upm_passthrough_tb
